// ===== design/ccsr_regs.vh
// Purpose: constants for the cache control and status register block
// Assumes: one 32-bit register, reached over a plain strobe port
// Notes: field positions and fixed codes of the control word
`ifndef CCSR_REGS_VH
`define CCSR_REGS_VH
`define CCSR_ADDR_CTRL 4'h0
`define CCSR_ADDR_W 4
`define CCSR_DREPL_HI 31
`define CCSR_DREPL_LO 30
`define CCSR_IREPL_HI 29
`define CCSR_IREPL_LO 28
`define CCSR_ISETS_HI 27
`define CCSR_ISETS_LO 26
`define CCSR_DSETS_HI 25
`define CCSR_DSETS_LO 24
`define CCSR_SNOOP_BIT 23
`define CCSR_DFLUSH_BIT 22
`define CCSR_IFLUSH_BIT 21
`define CCSR_PARW_HI 20
`define CCSR_PARW_LO 19
`define CCSR_PTEST_HI 18
`define CCSR_PTEST_LO 17
`define CCSR_IBURST_BIT 16
`define CCSR_IPEND_BIT 15
`define CCSR_DPEND_BIT 14
`define CCSR_ITE_HI 13
`define CCSR_ITE_LO 12
`define CCSR_IDE_HI 11
`define CCSR_IDE_LO 10
`define CCSR_DTE_HI 9
`define CCSR_DTE_LO 8
`define CCSR_DDE_HI 7
`define CCSR_DDE_LO 6
`define CCSR_DFRZ_BIT 5
`define CCSR_IFRZ_BIT 4
`define CCSR_DSTATE_HI 3
`define CCSR_DSTATE_LO 2
`define CCSR_ISTATE_HI 1
`define CCSR_ISTATE_LO 0
`define CCSR_REPL_LRU 2'h3
`define CCSR_WAYS_4 2'h3
`define CCSR_WAYS_2 2'h1
`define CCSR_PARW_2 2'h2
`define CCSR_CNT_MAX 2'h3
`define CCSR_ST_FROZEN 2'h1
`define CCSR_ST_ON 2'h3
`define CCSR_ST_OFF 2'h0
`define CCSR_ICACHE_LINES 256
`define CCSR_DCACHE_LINES 256
`define CCSR_ZERO32 32'h0000_0000
`endif

// ===== design/ccsr_flush.v
// Purpose: walks every line index of one cache to invalidate it
// Assumes: one line invalidated per clock
// Notes: pending clears the cycle after the last line
`timescale 1ns/1ps
`include "ccsr_regs.vh"
module ccsr_flush #(
    parameter LINES = 256,
    parameter IDX_W = 8
) (
    input wire sys_clk_in,
    input wire reset_in,
    input wire start_in,
    output reg pending_out,
    output reg inval_out,
    output reg [IDX_W-1:0] index_out
);
    localparam integer LAST_I = LINES - 1;
    localparam [IDX_W-1:0] LAST = LAST_I[IDX_W-1:0];
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            pending_out <= 1'b0;
            inval_out <= 1'b0;
            index_out <= {IDX_W{1'b0}};
        end else if (inval_out && index_out == LAST) begin
            inval_out <= 1'b0;
            pending_out <= 1'b0;
            index_out <= {IDX_W{1'b0}};
        end else if (inval_out) begin
            index_out <= index_out + 1'b1;
        end else if (start_in) begin
            // a start during a flush is absorbed by the running walk
            pending_out <= 1'b1;
            inval_out <= 1'b1;
            index_out <= {IDX_W{1'b0}};
        end
    end
endmodule // ccsr_flush

// ===== design/ccsr_top.v
// Purpose: cache control and status register with flush sequencers
// Assumes: synchronous inputs, single 25 MHz clock, synchronous reset
// Notes: read data appears the cycle after the read strobe
// Operation
// (R1) data cache replacement field reads fixed 11, LRU
// (R2) instruction cache replacement field reads fixed 11, LRU
// (R3) instruction cache associativity reads 11, four ways
// (R4) data cache associativity reads 01, two ways
// (R5) bit 23 enables data cache snooping
// (R6) writing one to bit 22 flushes data cache; reads zero
// (R7) writing one to bit 21 flushes instruction cache; reads zero
// (R8) parity width field reads fixed 10, two bits
// (R9) parity test bits XOR into parity on diagnostic writes
// (R10) bit 16 enables burst fill on instruction fetch
// (R11) bit 15 high while instruction flush runs
// (R12) bit 14 high while data flush runs
// (R13) instruction tag parity error increments its counter
// (R14) instruction data parity error increments its counter
// (R15) data tag parity error increments its counter
// (R16) data cache data parity error increments its counter
// (R17) counters saturate at 11; software clears to zero
// (R18) bit 5 freezes data cache on asynchronous interrupt
// (R19) bit 4 freezes instruction cache on asynchronous interrupt
// (R20) data state: low bit zero off, 01 frozen, 11 enabled
// (R21) instruction state decoded the same way
// (R22) flush invalidates every line; pending clears after last line
`timescale 1ns/1ps
`include "ccsr_regs.vh"
module ccsr_top #(
    parameter ILINES = `CCSR_ICACHE_LINES,
    parameter DLINES = `CCSR_DCACHE_LINES,
    parameter IDX_W = 8
) (
    input wire sys_clk_in,
    input wire reset_in,
    input wire [`CCSR_ADDR_W-1:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire irq_taken_in,
    input wire itag_perr_in,
    input wire idata_perr_in,
    input wire dtag_perr_in,
    input wire ddata_perr_in,
    input wire diag_wr_in,
    input wire [1:0] tag_par_in,
    input wire [1:0] data_par_in,
    output reg [1:0] tag_par_out,
    output reg [1:0] data_par_out,
    output reg dcache_snoop_enable_out,
    output reg instr_burst_fill_out,
    output reg dcache_enable_out,
    output reg dcache_frozen_out,
    output reg icache_enable_out,
    output reg icache_frozen_out,
    output reg dcache_inval_out,
    output reg [IDX_W-1:0] dcache_index_out,
    output reg icache_inval_out,
    output reg [IDX_W-1:0] icache_index_out
);
    reg dcache_snoop_enable;
    reg [1:0] ptest;
    reg instr_burst_fill;
    reg [1:0] ite_cnt;
    reg [1:0] ide_cnt;
    reg [1:0] dte_cnt;
    reg [1:0] dde_cnt;
    reg dcache_freeze_on_irq;
    reg icache_freeze_on_irq;
    reg [1:0] dstate;
    reg [1:0] istate;
    reg [1:0] next_dstate;
    reg [1:0] next_istate;
    wire wr_hit;
    wire rd_hit;
    wire dflush_go;
    wire iflush_go;
    wire dcache_flush_pending;
    wire icache_flush_pending;
    wire d_inval;
    wire i_inval;
    wire [IDX_W-1:0] d_index;
    wire [IDX_W-1:0] i_index;
    wire [31:0] cache_control;

    // saturating error counter; a write loads the written field, a hit in the same cycle still counts
    function [1:0] err_next;
        input [1:0] cur;
        input hit;
        input clr;
        input [1:0] wval;
        reg [1:0] base;
        begin
            base = clr ? wval : cur;
            if (hit && base != `CCSR_CNT_MAX)
                err_next = base + 2'h1;
            else
                err_next = base;
        end
    endfunction

    // state field decode: enabled only on 11, frozen on 01, else off
    function [1:0] state_decode;
        input [1:0] st;
        begin
            state_decode = {st == `CCSR_ST_ON, st == `CCSR_ST_FROZEN};
        end
    endfunction

    assign wr_hit = wr_in && addr_in == `CCSR_ADDR_CTRL;
    assign rd_hit = rd_in && addr_in == `CCSR_ADDR_CTRL;
    assign dflush_go = wr_hit && wdata_in[`CCSR_DFLUSH_BIT]; // R6
    assign iflush_go = wr_hit && wdata_in[`CCSR_IFLUSH_BIT]; // R7

    ccsr_flush #(
        .LINES(DLINES),
        .IDX_W(IDX_W)
    ) u_dflush (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .start_in(dflush_go),
        .pending_out(dcache_flush_pending),
        .inval_out(d_inval),
        .index_out(d_index)
    );

    ccsr_flush #(
        .LINES(ILINES),
        .IDX_W(IDX_W)
    ) u_iflush (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .start_in(iflush_go),
        .pending_out(icache_flush_pending),
        .inval_out(i_inval),
        .index_out(i_index)
    );

    assign cache_control = {
        `CCSR_REPL_LRU, // R1
        `CCSR_REPL_LRU, // R2
        `CCSR_WAYS_4, // R3
        `CCSR_WAYS_2, // R4
        dcache_snoop_enable,
        1'b0, // R6
        1'b0, // R7
        `CCSR_PARW_2, // R8
        ptest,
        instr_burst_fill,
        icache_flush_pending, // R11
        dcache_flush_pending, // R12
        ite_cnt,
        ide_cnt,
        dte_cnt,
        dde_cnt,
        dcache_freeze_on_irq,
        icache_freeze_on_irq,
        dstate,
        istate
    };

    // freeze on interrupt overrides a same-cycle write only for an enabled cache
    always @* begin
        next_dstate = dstate;
        next_istate = istate;
        if (wr_hit) begin
            next_dstate = wdata_in[`CCSR_DSTATE_HI:`CCSR_DSTATE_LO];
            next_istate = wdata_in[`CCSR_ISTATE_HI:`CCSR_ISTATE_LO];
        end
        if (irq_taken_in && dcache_freeze_on_irq && next_dstate[0]) begin
            next_dstate = `CCSR_ST_FROZEN; // R18
        end
        if (irq_taken_in && icache_freeze_on_irq && next_istate[0]) begin
            next_istate = `CCSR_ST_FROZEN; // R19
        end
    end

    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            dcache_snoop_enable <= 1'b0;
            ptest <= 2'h0;
            instr_burst_fill <= 1'b0;
            ite_cnt <= 2'h0;
            ide_cnt <= 2'h0;
            dte_cnt <= 2'h0;
            dde_cnt <= 2'h0;
            dcache_freeze_on_irq <= 1'b0;
            icache_freeze_on_irq <= 1'b0;
            dstate <= `CCSR_ST_OFF;
            istate <= `CCSR_ST_OFF;
        end else begin
            if (wr_hit) begin
                dcache_snoop_enable <= wdata_in[`CCSR_SNOOP_BIT];
                ptest <= wdata_in[`CCSR_PTEST_HI:`CCSR_PTEST_LO];
                instr_burst_fill <= wdata_in[`CCSR_IBURST_BIT];
                dcache_freeze_on_irq <= wdata_in[`CCSR_DFRZ_BIT];
                icache_freeze_on_irq <= wdata_in[`CCSR_IFRZ_BIT];
            end
            ite_cnt <= err_next(ite_cnt, itag_perr_in, wr_hit,
                wdata_in[`CCSR_ITE_HI:`CCSR_ITE_LO]); // R13 R17
            ide_cnt <= err_next(ide_cnt, idata_perr_in, wr_hit,
                wdata_in[`CCSR_IDE_HI:`CCSR_IDE_LO]); // R14 R17
            dte_cnt <= err_next(dte_cnt, dtag_perr_in, wr_hit,
                wdata_in[`CCSR_DTE_HI:`CCSR_DTE_LO]); // R15 R17
            dde_cnt <= err_next(dde_cnt, ddata_perr_in, wr_hit,
                wdata_in[`CCSR_DDE_HI:`CCSR_DDE_LO]); // R16 R17
            dstate <= next_dstate;
            istate <= next_istate;
        end
    end

    // outputs registered; they trail the control word by one cycle
    always @(posedge sys_clk_in) begin
        if (reset_in) begin
            rdata_out <= `CCSR_ZERO32;
            tag_par_out <= 2'h0;
            data_par_out <= 2'h0;
            dcache_snoop_enable_out <= 1'b0;
            instr_burst_fill_out <= 1'b0;
            dcache_enable_out <= 1'b0;
            dcache_frozen_out <= 1'b0;
            icache_enable_out <= 1'b0;
            icache_frozen_out <= 1'b0;
            dcache_inval_out <= 1'b0;
            dcache_index_out <= {IDX_W{1'b0}};
            icache_inval_out <= 1'b0;
            icache_index_out <= {IDX_W{1'b0}};
        end else begin
            // unmapped reads and idle cycles return zero
            rdata_out <= rd_hit ? cache_control : `CCSR_ZERO32;
            tag_par_out <= diag_wr_in ? (tag_par_in ^ ptest) : tag_par_in; // R9
            data_par_out <= diag_wr_in ? (data_par_in ^ ptest) : data_par_in; // R9
            dcache_snoop_enable_out <= dcache_snoop_enable; // R5
            instr_burst_fill_out <= instr_burst_fill; // R10
            {dcache_enable_out, dcache_frozen_out} <= state_decode(dstate); // R20
            {icache_enable_out, icache_frozen_out} <= state_decode(istate); // R21
            dcache_inval_out <= d_inval; // R22
            dcache_index_out <= d_index;
            icache_inval_out <= i_inval; // R22
            icache_index_out <= i_index;
        end
    end
endmodule // ccsr_top

// ===== test/ccsr_top_asserts.sv
// Purpose: port-level checks of the cache control register block
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every ccsr_top instance
`timescale 1ns/1ps
`include "ccsr_regs.vh"
module ccsr_chk #(parameter ILINES = 256, parameter DLINES = 256, parameter IDX_W = 8) (
    input wire sys_clk_in,
    input wire reset_in,
    input wire [`CCSR_ADDR_W-1:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire diag_wr_in,
    input wire [1:0] tag_par_in,
    input wire [1:0] tag_par_out,
    input wire dcache_snoop_enable_out,
    input wire dcache_enable_out,
    input wire dcache_frozen_out,
    input wire dcache_inval_out,
    input wire [IDX_W-1:0] dcache_index_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);
    a_read_fixed: assert property (rd_in && addr_in == 0 |=>
        {rdata_out[31:24], rdata_out[22:19]} == 12'hFD2) else $error("fixed fields wrong");
    a_read_idle: assert property (!rd_in |=> rdata_out == 32'h0000_0000) else $error("stray data");
    a_par_pass: assert property (!diag_wr_in |=> tag_par_out == $past(tag_par_in))
        else $error("parity altered outside diagnostics");
    a_snoop_lag: assert property (wr_in && addr_in == 0 |=> ##1
        dcache_snoop_enable_out == $past(wdata_in[23], 2)) else $error("snoop enable wrong");
    a_dflush_start: assert property (wr_in && addr_in == 0 && wdata_in[22] && !dcache_inval_out
        && !$past(wr_in && addr_in == 0 && wdata_in[22])
        |=> ##1 dcache_inval_out && dcache_index_out == 0) else $error("flush not started");
    a_inval_step: assert property (dcache_inval_out && dcache_index_out != DLINES - 1 |=>
        dcache_inval_out && dcache_index_out == $past(dcache_index_out) + 1)
        else $error("flush index skipped");
    a_inval_end: assert property (dcache_inval_out && dcache_index_out == DLINES - 1 |=>
        !dcache_inval_out) else $error("flush overran");
    a_state_excl: assert property (!(dcache_enable_out && dcache_frozen_out))
        else $error("enabled and frozen together");
endmodule // ccsr_chk
bind ccsr_top ccsr_chk #(.ILINES(ILINES), .DLINES(DLINES), .IDX_W(IDX_W)) u_chk (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .diag_wr_in(diag_wr_in),
    .tag_par_in(tag_par_in), .tag_par_out(tag_par_out),
    .dcache_snoop_enable_out(dcache_snoop_enable_out), .dcache_enable_out(dcache_enable_out),
    .dcache_frozen_out(dcache_frozen_out), .dcache_inval_out(dcache_inval_out),
    .dcache_index_out(dcache_index_out));

// ===== test/testbench.sv
// Purpose: directed test of the cache control register block
// Assumes: eight-line caches keep each flush short
// Notes: ctl holds the last word written to address 0, updated for the freezes and error counts the test causes
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module testbench;
    localparam int LN = 8;
    logic sys_clk_in = 0, reset_in = 1, wr_in = 0, rd_in = 0, irq_taken_in = 0, diag_wr_in = 0;
    logic itag_perr_in = 0, idata_perr_in = 0, dtag_perr_in = 0, ddata_perr_in = 0;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0000_0000, ctl = 32'h0000_0000;
    logic [1:0] tag_par_in = 2'h0, data_par_in = 2'h0;
    wire [31:0] rdata_out;
    wire [1:0] tag_par_out, data_par_out;
    wire [7:0] dcache_index_out, icache_index_out;
    wire dcache_snoop_enable_out, instr_burst_fill_out, dcache_enable_out, dcache_frozen_out;
    wire icache_enable_out, icache_frozen_out, dcache_inval_out, icache_inval_out;
    int miscompares = 0, samples_checked = 0, dcnt = 0, icnt = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) begin
        dcnt <= dcnt + int'(dcache_inval_out);
        icnt <= icnt + int'(icache_inval_out);
        if (dcache_inval_out) `CHK(dcache_index_out, 8'(dcnt % LN))
        if (icache_inval_out) `CHK(icache_index_out, 8'(icnt % LN))
    end
    ccsr_top #(.ILINES(LN), .DLINES(LN), .IDX_W(8)) u_dut (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_taken_in(irq_taken_in),
        .itag_perr_in(itag_perr_in), .idata_perr_in(idata_perr_in),
        .dtag_perr_in(dtag_perr_in), .ddata_perr_in(ddata_perr_in), .diag_wr_in(diag_wr_in),
        .tag_par_in(tag_par_in), .data_par_in(data_par_in), .tag_par_out(tag_par_out),
        .data_par_out(data_par_out), .dcache_snoop_enable_out(dcache_snoop_enable_out),
        .instr_burst_fill_out(instr_burst_fill_out), .dcache_enable_out(dcache_enable_out),
        .dcache_frozen_out(dcache_frozen_out), .icache_enable_out(icache_enable_out),
        .icache_frozen_out(icache_frozen_out), .dcache_inval_out(dcache_inval_out),
        .dcache_index_out(dcache_index_out), .icache_inval_out(icache_inval_out),
        .icache_index_out(icache_index_out));
    // fixed fields over the writable bits; flush and pending bits never kept
    function automatic logic [31:0] expw();
        return 32'hFD10_0000 | (ctl & 32'h0087_3FFF);
    endfunction
    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        if (a == 4'h0) ctl = d;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 `CHK(rdata_out, e)
    endtask
    // e high: all four parity errors, low: an interrupt taken
    task automatic pulse(input logic e);
        @(posedge sys_clk_in);
        {itag_perr_in, idata_perr_in, dtag_perr_in, ddata_perr_in} <= {4{e}};
        irq_taken_in <= ~e;
        @(posedge sys_clk_in);
        {itag_perr_in, idata_perr_in, dtag_perr_in, ddata_perr_in} <= 4'h0;
        irq_taken_in <= 1'b0;
    endtask
    task automatic flush(input int b, input int p);
        int d0, i0, n;
        d0 = dcnt;
        i0 = icnt;
        // earlier flush bits must not ride along and start the other cache
        wr(4'h0, (ctl & 32'hFF9F_FFFF) | (32'h1 << b));
        rd(4'h0, expw() | (32'h1 << p));
        for (n = 0; n < 40 && (dcache_inval_out || icache_inval_out); n++) begin
            @(posedge sys_clk_in);
            #1;
        end
        if (n >= 40) miscompares++;
        `CHK(dcnt - d0, b == 22 ? LN : 0)
        `CHK(icnt - i0, b == 21 ? LN : 0)
        rd(4'h0, expw());
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk_in);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        rd(4'h0, 32'hFD10_0000);
        wr(4'h5, 32'h0087_003F);
        rd(4'h3, 32'h0000_0000);
        rd(4'h0, 32'hFD10_0000);
        wr(4'h0, 32'h0087_003F);
        rd(4'h0, expw());
        `CHK({dcache_snoop_enable_out, instr_burst_fill_out, dcache_enable_out}, 3'h7)
        @(posedge sys_clk_in);
        diag_wr_in <= 1'b1;
        tag_par_in <= 2'h1;
        data_par_in <= 2'h2;
        @(posedge sys_clk_in);
        diag_wr_in <= 1'b0;
        #1 `CHK({tag_par_out, data_par_out}, 4'h9)
        @(posedge sys_clk_in);
        #1 `CHK({tag_par_out, data_par_out}, 4'h6)
        pulse(1'b0);
        ctl[3:0] = 4'h5;
        rd(4'h0, expw());
        `CHK({dcache_frozen_out, icache_frozen_out, dcache_enable_out}, 3'h6)
        wr(4'h0, 32'h0000_000F);
        pulse(1'b0);
        rd(4'h0, expw());
        for (int s = 0; s < 4; s++) begin
            wr(4'h0, 32'(s * 5));
            rd(4'h0, expw());
            `CHK({dcache_enable_out, dcache_frozen_out, icache_enable_out, icache_frozen_out},
                {2{s == 3, s == 1}})
        end
        for (int k = 1; k < 5; k++) begin
            pulse(1'b1);
            ctl[13:6] = {4{k > 3 ? 2'h3 : 2'(k)}};
            rd(4'h0, expw());
        end
        wr(4'h0, 32'h0000_000F);
        rd(4'h0, expw());
        flush(22, 14);
        flush(21, 15);
        give_verdict();
    end
endmodule // testbench
